// >>> logic/irqp_pkg.sv
// Constants for the interrupt priority register bank.
// Assumes a 32-bit AXI4-Lite register bus and 2-bit priority levels.
package irqp_pkg;
  localparam int IRQP_LINES = 32;
  localparam int IRQP_LINES_PER_REG = 4;
  localparam int IRQP_LANE_W = 8;
  localparam int IRQP_LEVEL_W = 2;
  localparam int IRQP_LEVEL_LSB = 6;
  localparam int IRQP_ADDR_W = 12;
  localparam logic [11:0] IRQP_BASE_OFS = 12'h300;
  localparam logic [11:0] IRQ0_3_PRIORITY_OFS = 12'h300;
  localparam logic [11:0] IRQ4_7_PRIORITY_OFS = 12'h304;
  localparam logic [11:0] IRQ8_11_PRIORITY_OFS = 12'h308;
  localparam logic [11:0] IRQ12_15_PRIORITY_OFS = 12'h30c;
  localparam logic [11:0] IRQ16_19_PRIORITY_OFS = 12'h310;
  localparam logic [11:0] IRQ20_23_PRIORITY_OFS = 12'h314;
  localparam logic [11:0] IRQ24_27_PRIORITY_OFS = 12'h318;
  localparam logic [11:0] IRQ28_31_PRIORITY_OFS = 12'h31c;
  localparam logic [1:0] IRQP_LEVEL_RESET = 2'h0;
  localparam logic [1:0] IRQP_LEVEL_MOST_URGENT = 2'h0;
  localparam logic [1:0] IRQP_LEVEL_LEAST_URGENT = 2'h3;
  localparam logic [31:0] IRQP_RSVD_MASK = 32'h3f3f_3f3f;
  localparam logic [1:0] IRQP_RESP_OKAY = 2'h0;
  localparam logic [1:0] IRQP_RESP_SLVERR = 2'h2;
endpackage

// >>> logic/irqp_arb_if.sv
// Carrier between the priority bank and its arbiter.
// Assumes one clock domain; levels are packed 2 bits per line.
`timescale 1ns/1ps
interface irqp_arb_if #(
  parameter int NUM_LINES = 32
);
  logic [2*NUM_LINES-1:0] levels;
  logic [NUM_LINES-1:0] req;
  logic grant_valid;
  logic [$clog2(NUM_LINES)-1:0] grant_id;
  logic [1:0] grant_level;
  modport bank (
    output levels,
    output req,
    input grant_valid,
    input grant_id,
    input grant_level
  );
  modport arb (
    input levels,
    input req,
    output grant_valid,
    output grant_id,
    output grant_level
  );
endinterface

// >>> logic/irqp_arbiter.sv
// Ranks requesting lines by stored priority level.
// Assumes req already holds pending-and-enabled lines.
`timescale 1ns/1ps
module irqp_arbiter
  import irqp_pkg::*;
#(
  parameter int NUM_LINES = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  irqp_arb_if.arb arb
);
  localparam int IDW = $clog2(NUM_LINES);

  logic found;
  logic [IDW-1:0] best_id;
  logic [1:0] best_lvl;
  logic grant_valid_r;
  logic [IDW-1:0] grant_id_r;
  logic [1:0] grant_level_r;

  ////////////////////////////////////////////////////////////////////////////
  // Walk down so that ties settle on the lowest line
  always_comb begin
    found = 1'b0;
    best_id = '0;
    best_lvl = IRQP_LEVEL_LEAST_URGENT;
    for (int i = NUM_LINES - 1; i >= 0; i--) begin
      if (arb.req[i] && (!found || arb.levels[2*i +: 2] <= best_lvl)) begin // RULE3 RULE8
        found = 1'b1;
        best_id = IDW'(i);
        best_lvl = arb.levels[2*i +: 2];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grant_valid_r <= 1'b0;
      grant_id_r <= '0;
      grant_level_r <= IRQP_LEVEL_RESET;
    end else if (ce) begin
      grant_valid_r <= found;
      grant_id_r <= best_id;
      grant_level_r <= best_lvl;
    end
  end

  assign arb.grant_valid = grant_valid_r;
  assign arb.grant_id = grant_id_r;
  assign arb.grant_level = grant_level_r;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic beaten(input logic [NUM_LINES-1:0] rq, input logic [2*NUM_LINES-1:0] lv,
                                  input logic [IDW-1:0] id);
    logic b;
    b = 1'b0;
    for (int j = 0; j < NUM_LINES; j++) begin
      if (rq[j] && (lv[2*j +: 2] < lv[2*id +: 2] || (lv[2*j +: 2] == lv[2*id +: 2] && j < int'(id))))
        b = 1'b1;
    end
    return b;
  endfunction

  grant_seen_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
    ce && (arb.req != '0) |=> grant_valid_r)
    else $error("Request present but no grant");
  grant_best_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
    ce && found |=> !beaten($past(arb.req), $past(arb.levels), grant_id_r)
      && grant_level_r == $past(arb.levels[2*best_id +: 2]))
    else $error("Grant is not the most urgent lowest line");
endmodule

// >>> logic/irqp_bank.sv
// Interrupt priority register bank with AXI4-Lite slave and arbiter.
// Assumes irq_req carries pending-and-enabled lines, sync to aclk.
// Functional notes
// RULE1: Each register holds four consecutive line levels
// RULE2: Two top bits of each byte lane stored
// RULE3: Level zero most urgent, three least urgent
// RULE4: Lower six bits per lane read zero
// RULE5: Software ignores and avoids reserved bits; the bench writes them nonzero on purpose
// RULE6: Registers at 0x300 to 0x30C, reset zero
// RULE7: Same layout continues to 0x31C, line 31
// RULE8: Smallest level wins, ties to lowest line
`timescale 1ns/1ps
module irqp_bank
  import irqp_pkg::*;
#(
  parameter int NUM_LINES = IRQP_LINES,
  parameter int ADDR_W = IRQP_ADDR_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_LINES-1:0] irq_req,
  output logic [2*NUM_LINES-1:0] irq_level,
  output logic irq_grant_valid,
  output logic [$clog2(NUM_LINES)-1:0] irq_grant_id,
  output logic [1:0] irq_grant_level
);
  localparam int NREG = NUM_LINES / IRQP_LINES_PER_REG;
  localparam int IW = $clog2(NREG);
  localparam int LW = IW + 2;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by both channels
  function automatic logic [IW:0] reg_decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - ADDR_W'(IRQP_BASE_OFS);
    return {d < ADDR_W'(4 * NREG), d[IW+1:2]}; // RULE6 RULE7
  endfunction

  logic [ADDR_W-1:0] awaddr_q;
  logic aw_full_r;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_full_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [2*NUM_LINES-1:0] level_r;
  logic [2*NUM_LINES-1:0] level_nxt;
  logic [31:0] rd_word;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire r_done = s_axi_rready & s_axi_rvalid;
  wire b_done = s_axi_bready & s_axi_bvalid;
  wire [IW:0] wr_dec = reg_decode(awaddr_q);
  wire [IW:0] rd_dec = reg_decode(s_axi_araddr);
  wire wr_hit = wr_dec[IW];
  wire [IW-1:0] wr_idx = wr_dec[IW-1:0];
  wire rd_hit = rd_dec[IW];
  wire [IW-1:0] rd_idx = rd_dec[IW-1:0];
  // Write commits only once both halves are held and the last answer is gone
  wire wr_go = aw_full_r & w_full_r & ~bvalid_r;

  // Handshakes gated by ce so no beat is taken while state is frozen
  assign s_axi_awready = ce & ~aw_full_r;
  assign s_axi_wready = ce & ~w_full_r;
  assign s_axi_bvalid = ce & bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ce & ~rvalid_r;
  assign s_axi_rvalid = ce & rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Level storage: one 2-bit field per line
  genvar g;
  generate
    for (g = 0; g < NUM_LINES; g++) begin : g_line
      localparam int R = g / IRQP_LINES_PER_REG;
      localparam int L = g % IRQP_LINES_PER_REG;
      wire we = wr_go & wr_hit & (wr_idx == IW'(R)) & wstrb_q[L]; // RULE1 RULE7
      assign level_nxt[2*g +: 2] = we ? wdata_q[IRQP_LANE_W*L + IRQP_LEVEL_LSB +: IRQP_LEVEL_W] // RULE2
                                      : level_r[2*g +: 2];
    end
    for (g = 0; g < IRQP_LINES_PER_REG; g++) begin : g_lane
      wire [LW-1:0] line = {rd_idx, 2'(g)};
      assign rd_word[IRQP_LANE_W*g + IRQP_LEVEL_LSB +: IRQP_LEVEL_W] = level_r[{line, 1'b0} +: 2]; // RULE2
      assign rd_word[IRQP_LANE_W*g +: IRQP_LEVEL_LSB] = '0; // RULE4
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_r <= '0; // RULE6
    end else if (ce) begin
      level_r <= level_nxt;
    end
  end

  assign irq_level = level_r;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      awaddr_q <= '0;
    end else if (ce) begin
      if (aw_take) begin
        aw_full_r <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_full_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_r <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (ce) begin
      if (w_take) begin
        w_full_r <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_full_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= IRQP_RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? IRQP_RESP_OKAY : IRQP_RESP_SLVERR;
      end else if (b_done) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel; unmapped reads answer zero with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= IRQP_RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_hit ? rd_word : '0;
        rresp_r <= rd_hit ? IRQP_RESP_OKAY : IRQP_RESP_SLVERR;
      end else if (r_done) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration of pending lines
  irqp_arb_if #(.NUM_LINES(NUM_LINES)) arb_bus ();

  assign arb_bus.levels = level_r;
  assign arb_bus.req = irq_req;
  assign irq_grant_valid = arb_bus.grant_valid;
  assign irq_grant_id = arb_bus.grant_id;
  assign irq_grant_level = arb_bus.grant_level;

  irqp_arbiter #(.NUM_LINES(NUM_LINES)) u_arb (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .arb(arb_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_commit_lane0;
    ce && wr_go && wr_hit && wstrb_q[0];
  endsequence
  sequence s_commit_lane3;
    ce && wr_go && wr_hit && wstrb_q[3];
  endsequence

  first_reg_a: assert property ((s_commit_lane0 and (wr_idx == '0)) |=> // RULE1
    level_r[1:0] == $past(wdata_q[7:6]))
    else $error("Line 0 level not taken from bits 7:6");
  top_lane_a: assert property ((s_commit_lane3 and (wr_idx == IW'(NREG - 1))) |=> // RULE7
    level_r[2*NUM_LINES-1 -: 2] == $past(wdata_q[31:30]))
    else $error("Last line level not taken from bits 31:30");
  lane_map_a: assert property (ce && ar_take && rd_hit && rd_idx == IW'(1) |=> // RULE2
    rdata_r[31:30] == $past(level_r[15:14]) && rdata_r[7:6] == $past(level_r[9:8]))
    else $error("Read lane does not match stored level");
  rsvd_zero_a: assert property (rvalid_r |-> (rdata_r & IRQP_RSVD_MASK) == '0) // RULE4
    else $error("Reserved bits read nonzero");
  reset_zero_a: assert property (!$past(aresetn) |-> level_r == '0 && !bvalid_r && !rvalid_r) // RULE6
    else $error("Levels not zero after reset");
  unmapped_err_a: assert property (ce && ar_take && !rd_hit |=> rresp_r == IRQP_RESP_SLVERR && rdata_r == '0)
    else $error("Unmapped read not answered with error");
  resp_hold_a: assert property (bvalid_r && !(ce && s_axi_bready) |=> bvalid_r && $stable(bresp_r))
    else $error("Write response dropped early");
  wr_answer_a: assert property (ce && wr_go |=> bvalid_r ##0 (bresp_r == (
    $past(wr_hit) ? IRQP_RESP_OKAY : IRQP_RESP_SLVERR)))
    else $error("Write commit not answered next cycle");
  freeze_a: assert property (!ce |=> $stable(level_r) && $stable(bvalid_r) && $stable(rvalid_r))
    else $error("State moved while clock enable low");

  ////////////////////////////////////////////////////////////////////////////
  // Bus beats as named steps; a held half must block its own channel
  sequence s_aw_beat;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence s_w_beat;
    s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_ar_beat;
    s_axi_arvalid && s_axi_arready && rd_hit;
  endsequence

  aw_block_a: assert property (s_aw_beat |=>
    !s_axi_awready && awaddr_q == $past(s_axi_awaddr))
    else $error("Write address not held after its beat");
  w_block_a: assert property (s_w_beat |=>
    !s_axi_wready && wdata_q == $past(s_axi_wdata) && wstrb_q == $past(s_axi_wstrb))
    else $error("Write data not held after its beat");
  pair_commit_a: assert property ((s_aw_beat and s_w_beat) ##1 !bvalid_r |->
    wr_go)
    else $error("Paired write beats not committed");
  rd_answer_a: assert property (s_ar_beat |=> // RULE6
    rvalid_r && rresp_r == IRQP_RESP_OKAY)
    else $error("Mapped read not answered next cycle");
  ar_block_a: assert property (rvalid_r |->
    !s_axi_arready)
    else $error("Read address taken while data pending");
  gate_ready_a: assert property (!ce |->
    !s_axi_awready && !s_axi_wready && !s_axi_arready && !s_axi_bvalid && !s_axi_rvalid)
    else $error("Handshake offered while clock enable low");
  rd_hold_a: assert property (rvalid_r && !(ce && s_axi_rready) |=>
    rvalid_r && $stable(rdata_r) && $stable(rresp_r))
    else $error("Read answer dropped or changed early");
  b_clear_a: assert property (ce && s_axi_bready && bvalid_r |=>
    !bvalid_r)
    else $error("Write response kept after it was taken");
  r_clear_a: assert property (ce && s_axi_rready && rvalid_r |=>
    !rvalid_r)
    else $error("Read answer kept after it was taken");

  ////////////////////////////////////////////////////////////////////////////
  // Lane mapping in both directions; a cleared strobe leaves its line alone
  strobe_keep_a: assert property (ce && wr_go && wr_hit && wr_idx == IW'(2) && !wstrb_q[0] |=> // RULE1
    $stable(level_r[17:16]))
    else $error("Line without strobe was written");
  wr_miss_a: assert property (ce && wr_go && !wr_hit |=> // RULE6
    $stable(level_r))
    else $error("Unmapped write changed a level");
  low_lane_a: assert property ((s_ar_beat and (rd_idx == '0)) |=> // RULE2
    rdata_r[15:14] == $past(level_r[3:2]) && rdata_r[23:22] == $past(level_r[5:4]))
    else $error("Middle lanes of first register misread");
  mid_lane_a: assert property (ce && wr_go && wr_hit && wr_idx == IW'(1) && wstrb_q[1] |=> // RULE2
    level_r[11:10] == $past(wdata_q[15:14]))
    else $error("Lane one level not taken from bits 15:14");
  upper_lane_a: assert property (ce && wr_go && wr_hit && wr_idx == IW'(2) && wstrb_q[2] |=> // RULE2
    level_r[21:20] == $past(wdata_q[23:22]))
    else $error("Lane two level not taken from bits 23:22");
  last_read_a: assert property ((s_ar_beat and (rd_idx == IW'(NREG - 1))) |=> // RULE7
    rdata_r[31:30] == $past(level_r[2*NUM_LINES-1 -: 2]))
    else $error("Last line level misread");
endmodule

// >>> sim/irqp_core_model.sv
// Far-side stand-in: the core raising pending, enabled lines.
// Assumes the bench hands it a pending pattern, sampled on aclk.
`timescale 1ns/1ps
module irqp_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] pend,
  output logic [31:0] irq_req
);
  // Registered so requests only move just after an edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req <= 32'h0000_0000;
    end else begin
      irq_req <= pend;
    end
  end
endmodule

// >>> sim/irqp_bank_tb.sv
// Self-checking bench for the priority bank over AXI4-Lite.
// Assumes the core model drives requests; prot is tied.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module irqp_bank_tb;
  import irqp_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic ce = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic [31:0] pend = 32'h0000_0000;
  logic awready, wready, bvalid, arready, rvalid, gvalid;
  logic [1:0] bresp, rresp, glevel;
  logic [31:0] rdata, irq_req;
  logic [63:0] irq_level;
  logic [4:0] gid;
  logic [1:0] lvl [32];
  int fails = 0, checks_done = 0, cyc = 0;
  ////////////////////////////////////////////////////////////////
  irqp_core_model core_u (.aclk(aclk), .aresetn(aresetn), .pend(pend), .irq_req(irq_req));
  irqp_bank #(.NUM_LINES(32), .ADDR_W(12)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq_req(irq_req), .irq_level(irq_level),
    .irq_grant_valid(gvalid), .irq_grant_id(gid), .irq_grant_level(glevel)
  );
  initial begin
    forever #2 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (fails == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      print_verdict();
    end
  end
  function automatic logic [31:0] word(input int idx);
    word = 32'h0000_0000;
    for (int k = 0; k < 4; k++) word[8*k+6 +: 2] = lvl[4*idx+k];
  endfunction
  function automatic logic [63:0] packed_lvl();
    for (int i = 0; i < 32; i++) packed_lvl[2*i +: 2] = lvl[i];
  endfunction
  // Smallest level wins, lowest line on a tie
  function automatic logic [4:0] winner(input logic [31:0] req);
    int b;
    b = -1;
    for (int i = 0; i < 32; i++) if (req[i] && (b < 0 || lvl[i] < lvl[b])) b = i;
    winner = (b < 0) ? 5'h00 : 5'(b);
  endfunction
  task automatic wr(input int idx, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    awaddr <= IRQP_BASE_OFS + 12'(idx * 4);
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
    if (er == IRQP_RESP_OKAY) for (int k = 0; k < 4; k++) if (s[k]) lvl[4*idx+k] = d[8*k+6 +: 2];
    // Idle edge so a following call never re-raises a strobe in the same step
    @(posedge aclk);
  endtask
  task automatic rd(input int idx, input logic [31:0] ed, input logic [1:0] er);
    araddr <= IRQP_BASE_OFS + 12'(idx * 4);
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    `CHK("rdata", ed, rdata)
    `CHK("rresp", er, rresp)
    @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] cases [5];
    cases = '{32'hffff_ffff, 32'h0000_0f00, 32'h8000_0001, 32'h0000_0000, 32'h0001_0010};
    foreach (lvl[i]) lvl[i] = 2'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 8; i++) rd(i, 32'h0000_0000, IRQP_RESP_OKAY);
    // Reserved bits set on every write; they must read back as zero
    for (int i = 0; i < 8; i++) begin
      wr(i, {i[1:0], 6'h3f, ~i[1:0], 6'h15, i[2:1], 6'h2a, 2'(i + 1), 6'h01}, 4'hf, IRQP_RESP_OKAY);
      rd(i, word(i), IRQP_RESP_OKAY);
      `CHK("levels", packed_lvl(), irq_level)
    end
    wr(2, 32'hffff_ffff, 4'b0100, IRQP_RESP_OKAY);
    rd(2, word(2), IRQP_RESP_OKAY);
    wr(8, 32'hffff_ffff, 4'hf, IRQP_RESP_SLVERR);
    wr(-1, 32'hffff_ffff, 4'hf, IRQP_RESP_SLVERR);
    rd(8, 32'h0000_0000, IRQP_RESP_SLVERR);
    rd(-1, 32'h0000_0000, IRQP_RESP_SLVERR);
    `CHK("levels", packed_lvl(), irq_level)
    // Frozen bank: nothing is taken or moves until ce returns, then the write lands
    ce <= 1'b0;
    fork
      wr(3, 32'h4000_0000, 4'h8, IRQP_RESP_OKAY);
      begin
        repeat (4) @(posedge aclk);
        `CHK("awready", 1'b0, awready)
        `CHK("frozen", packed_lvl(), irq_level)
        ce <= 1'b1;
      end
    join
    rd(3, word(3), IRQP_RESP_OKAY);
    foreach (cases[c]) begin
      pend <= cases[c];
      repeat (3) @(posedge aclk);
      `CHK("gvalid", |cases[c], gvalid)
      if (|cases[c]) begin
        `CHK("gid", winner(cases[c]), gid)
        `CHK("glevel", lvl[winner(cases[c])], glevel)
      end
    end
    print_verdict();
  end
endmodule
